// >>> mscr_config_regs.sv
// Gyro and accelerometer configuration registers with their decoded settings,
// output-rate divider and low-power duty cycling of the accelerometer.
// Assumes the host port is already deserialised into single-cycle strobes on ref_clk.
`timescale 1ns/100ps
module mscr_config_regs
    import mscr_pkg::*;
#(
    parameter int ON_BYPASS_CYC = ON_TIME_BYPASS_CYC,
    parameter int ON_AVG4_CYC   = ON_TIME_AVG4_CYC,
    parameter int ON_AVG8_CYC   = ON_TIME_AVG8_CYC,
    parameter int ON_AVG16_CYC  = ON_TIME_AVG16_CYC,
    parameter int ON_AVG32_CYC  = ON_TIME_AVG32_CYC
)(
    input  wire logic                    ref_clk,
    input  wire logic                    rst_n,
    input  wire logic [6:0]              regAddr,
    input  wire logic                    regWrEn,
    input  wire logic [7:0]              regWrData,
    input  wire logic                    regRdEn,
    output logic [7:0]                   regRdData,
    input  wire logic [7:0]              outputRateDivider,
    input  wire logic                    internalRate1k,
    input  wire logic                    internalSampleTick,
    input  wire logic [2:0]              gyroFilterCode,
    input  wire logic                    accLowPowerMode,
    output logic [2:0]                   gyroSelfTestEn,
    output logic [2:0]                   accSelfTestEn,
    output logic [11:0]                  gyroFullScaleDps,
    output logic [4:0]                   accFullScaleG,
    output mscr_pkg::mscr_gyro_bw_e      gyroBwSel,
    output logic [2:0]                   gyroFilterCodeUsed,
    output mscr_pkg::mscr_acc_bw_e       accBwSel,
    output logic [12:0]                  fifoSizeBytes,
    output logic [5:0]                   accAvgSamples,
    output logic                         outputSampleTick,
    output logic                         accPowerOn
);
    import mscr_pkg::*;

    logic [7:0]   gyroSetup_reg;
    logic [7:0]   accRange_reg;
    logic [7:0]   accFilter_reg;
    logic [7:0]   rateCnt_reg;
    logic [17:0]  onCycles_next;
    logic         accBypass;
    logic         rateHit;
    logic         lpStart;

    assign accBypass = accFilter_reg[ACC_BYP_BIT];

    // Masked writes keep reserved positions at zero
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            gyroSetup_reg <= REG_RESET_VAL;
            accRange_reg  <= REG_RESET_VAL;
            accFilter_reg <= REG_RESET_VAL;
        end else if (regWrEn) begin
            case (regAddr)
                GYRO_SETUP_ADDR: gyroSetup_reg <= regWrData & GYRO_WR_MASK;
                ACC_RANGE_ADDR:  accRange_reg  <= regWrData & ACC_RANGE_WR_MASK;
                ACC_FILTER_ADDR: accFilter_reg <= regWrData & ACC_FILTER_WR_MASK;
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            regRdData <= READ_ZERO;
        end else if (regRdEn) begin
            case (regAddr)
                GYRO_SETUP_ADDR: regRdData <= gyroSetup_reg;
                ACC_RANGE_ADDR:  regRdData <= accRange_reg;
                ACC_FILTER_ADDR: regRdData <= accFilter_reg;
                default:         regRdData <= READ_ZERO;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            gyroSelfTestEn <= 3'h0;
            accSelfTestEn  <= 3'h0;
        end else begin
            gyroSelfTestEn <= gyroSetup_reg[ST_MSB:ST_LSB];
            accSelfTestEn  <= accRange_reg[ST_MSB:ST_LSB];
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            gyroFullScaleDps <= GYRO_FS_250;
            accFullScaleG    <= ACC_FS_2G;
        end else begin
            case (gyroSetup_reg[RANGE_MSB:RANGE_LSB])
                CODE0:   gyroFullScaleDps <= GYRO_FS_250;
                CODE1:   gyroFullScaleDps <= GYRO_FS_500;
                CODE2:   gyroFullScaleDps <= GYRO_FS_1000;
                default: gyroFullScaleDps <= GYRO_FS_2000;
            endcase
            case (accRange_reg[RANGE_MSB:RANGE_LSB])
                CODE0:   accFullScaleG <= ACC_FS_2G;
                CODE1:   accFullScaleG <= ACC_FS_4G;
                CODE2:   accFullScaleG <= ACC_FS_8G;
                default: accFullScaleG <= ACC_FS_16G;
            endcase
        end
    end

    // Gyro path: bit 0 wins over bit 1, code 7 falls back to the wide filter
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            gyroBwSel          <= GYRO_BW_BY_CODE;
            gyroFilterCodeUsed <= 3'h0;
        end else begin
            gyroFilterCodeUsed <= gyroFilterCode;
            if (gyroSetup_reg[GYRO_FCHB_LSB]) begin
                gyroBwSel <= GYRO_BW_8173;
            end else if (gyroSetup_reg[GYRO_FCHB_MSB] || gyroFilterCode == FILT_CODE7) begin
                gyroBwSel <= GYRO_BW_3281;
            end else begin
                gyroBwSel <= GYRO_BW_BY_CODE;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            accBwSel <= ACC_BW_218;
        end else if (accBypass) begin
            accBwSel <= ACC_BW_1046;
        end else begin
            case (accFilter_reg[DLPF_MSB:DLPF_LSB])
                3'h0:    accBwSel <= ACC_BW_218;
                3'h1:    accBwSel <= ACC_BW_218;
                3'h2:    accBwSel <= ACC_BW_99;
                3'h3:    accBwSel <= ACC_BW_45;
                3'h4:    accBwSel <= ACC_BW_21;
                3'h5:    accBwSel <= ACC_BW_10;
                3'h6:    accBwSel <= ACC_BW_5;
                default: accBwSel <= ACC_BW_420;
            endcase
        end
    end

    // Size change takes effect at once; flushing the FIFO is the host's job
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            fifoSizeBytes <= FIFO_512B;
        end else begin
            case (accFilter_reg[FIFO_MSB:FIFO_LSB])
                CODE0:   fifoSizeBytes <= FIFO_512B;
                CODE1:   fifoSizeBytes <= FIFO_1KB;
                CODE2:   fifoSizeBytes <= FIFO_2KB;
                default: fifoSizeBytes <= FIFO_4KB;
            endcase
        end
    end

    // Averaging and on-time depend only on accel fields, never on gyro setup
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            accAvgSamples <= AVG_4;
        end else if (accLowPowerMode && accBypass) begin
            accAvgSamples <= AVG_1;
        end else begin
            case (accFilter_reg[DEC2_MSB:DEC2_LSB])
                CODE0:   accAvgSamples <= AVG_4;
                CODE1:   accAvgSamples <= AVG_8;
                CODE2:   accAvgSamples <= AVG_16;
                default: accAvgSamples <= AVG_32;
            endcase
        end
    end

    always_comb begin
        if (accBypass) begin
            onCycles_next = ON_CNT_W'(ON_BYPASS_CYC);
        end else begin
            case (accFilter_reg[DEC2_MSB:DEC2_LSB])
                CODE0:   onCycles_next = ON_CNT_W'(ON_AVG4_CYC);
                CODE1:   onCycles_next = ON_CNT_W'(ON_AVG8_CYC);
                CODE2:   onCycles_next = ON_CNT_W'(ON_AVG16_CYC);
                default: onCycles_next = ON_CNT_W'(ON_AVG32_CYC);
            endcase
        end
    end

    // Divider is bypassed unless the internal rate is 1 kHz
    assign rateHit = internalSampleTick && (!internalRate1k || rateCnt_reg == outputRateDivider);

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rateCnt_reg <= DIV_ZERO;
        end else if (internalSampleTick) begin
            rateCnt_reg <= rateHit ? DIV_ZERO : rateCnt_reg + DIV_ONE;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            outputSampleTick <= 1'b0;
        end else begin
            outputSampleTick <= rateHit;
        end
    end

    assign lpStart = accLowPowerMode && outputSampleTick;

    mscr_duty_timer uDutyTimer (
        .ref_clk  (ref_clk),
        .rst_n    (rst_n),
        .start    (lpStart),
        .onCycles (onCycles_next),
        .powerOn  (accPowerOn)
    );

    AST_GYRO_FS_2000: assert property (@(posedge ref_clk) disable iff (!rst_n)
        gyroSetup_reg[RANGE_MSB:RANGE_LSB] == CODE3 |=> gyroFullScaleDps == GYRO_FS_2000)
        else $error("gyro full scale not 2000 dps for code 3");
    AST_ACC_FS_4G: assert property (@(posedge ref_clk) disable iff (!rst_n)
        regWrEn && regAddr == ACC_RANGE_ADDR && regWrData[RANGE_MSB:RANGE_LSB] == CODE1
        ##1 !(regWrEn && regAddr == ACC_RANGE_ADDR) |=> accFullScaleG == ACC_FS_4G)
        else $error("accel full scale not 4g two cycles after write");
    AST_GYRO_BYPASS: assert property (@(posedge ref_clk) disable iff (!rst_n)
        gyroSetup_reg[GYRO_FCHB_LSB] |=> gyroBwSel == GYRO_BW_8173)
        else $error("gyro bypass bit did not select 8173 Hz");
    AST_GYRO_BY_CODE: assert property (@(posedge ref_clk) disable iff (!rst_n)
        gyroSetup_reg[GYRO_FCHB_MSB:GYRO_FCHB_LSB] == CODE0 && gyroFilterCode != FILT_CODE7
        |=> gyroBwSel == GYRO_BW_BY_CODE && gyroFilterCodeUsed == $past(gyroFilterCode))
        else $error("gyro not filtered by code with bits 00");
    AST_FIFO_SIZE: assert property (@(posedge ref_clk) disable iff (!rst_n)
        accFilter_reg[FIFO_MSB:FIFO_LSB] == CODE3 |=> fifoSizeBytes == FIFO_4KB)
        else $error("fifo size not 4 KB for code 3");
    AST_AVG_32: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !accBypass && accFilter_reg[DEC2_MSB:DEC2_LSB] == CODE3 |=> accAvgSamples == AVG_32)
        else $error("averaging not 32 for code 3");
    AST_ACC_BYPASS: assert property (@(posedge ref_clk) disable iff (!rst_n)
        accBypass |=> accBwSel == ACC_BW_1046)
        else $error("accel bypass did not give 1046 Hz");
    AST_ACC_CODE7: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !accBypass && accFilter_reg[DLPF_MSB:DLPF_LSB] == FILT_CODE7 |=> accBwSel == ACC_BW_420)
        else $error("accel code 7 did not give 420 Hz");
    AST_DIV_ZERO: assert property (@(posedge ref_clk) disable iff (!rst_n)
        internalSampleTick && internalRate1k && rateCnt_reg == outputRateDivider
        |=> outputSampleTick ##1 !outputSampleTick || internalSampleTick)
        else $error("divider terminal count gave no output tick");
    AST_NO_DIV: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !internalRate1k && internalSampleTick |=> outputSampleTick)
        else $error("divider applied away from 1 kHz rate");
    AST_LP_POWER: assert property (@(posedge ref_clk) disable iff (!rst_n)
        lpStart && !accPowerOn && !$past(accPowerOn) |=> accPowerOn)
        else $error("low-power window did not open");
    AST_LP_AVG1: assert property (@(posedge ref_clk) disable iff (!rst_n)
        accLowPowerMode && accBypass |=> accAvgSamples == AVG_1)
        else $error("low-power bypass not single average");
    AST_RSVD_ZERO: assert property (@(posedge ref_clk) disable iff (!rst_n)
        regRdEn && regAddr == ACC_RANGE_ADDR |=> regRdData[DLPF_MSB:DLPF_LSB] == 3'h0)
        else $error("reserved accel range bits read nonzero");

    COV_LP_WINDOW: cover property (@(posedge ref_clk) disable iff (!rst_n)
        lpStart ##1 accPowerOn);
    COV_DIV_TICK: cover property (@(posedge ref_clk) disable iff (!rst_n)
        internalRate1k && rateHit && outputRateDivider != DIV_ZERO);
    COV_GYRO_WR: cover property (@(posedge ref_clk) disable iff (!rst_n)
        regWrEn && regAddr == GYRO_SETUP_ADDR ##2 gyroFullScaleDps == GYRO_FS_2000);

endmodule

// >>> mscr_duty_timer.sv
// On-time timer for the duty-cycled accelerometer measurement window.
// Assumes start is a one-cycle pulse on ref_clk and onCycles is at least one.
`timescale 1ns/100ps
module mscr_duty_timer
    import mscr_pkg::*;
(
    input  wire logic                ref_clk,
    input  wire logic                rst_n,
    input  wire logic                start,
    input  wire logic [17:0]         onCycles,
    output logic                     powerOn
);

    logic [17:0] remain_reg;

    // A start that lands inside a running window is dropped, so windows never stretch
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            remain_reg <= ON_CNT_ZERO;
        end else if (start && remain_reg == ON_CNT_ZERO) begin
            remain_reg <= onCycles;
        end else if (remain_reg != ON_CNT_ZERO) begin
            remain_reg <= remain_reg - ON_CNT_ONE;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            powerOn <= 1'b0;
        end else if (start && remain_reg == ON_CNT_ZERO) begin
            powerOn <= 1'b1;
        end else if (remain_reg == ON_CNT_ONE) begin
            powerOn <= 1'b0;
        end
    end

endmodule

// >>> mscr_host_model.sv
// Host side of the parallel register port: one-cycle write and read strobes.
// Assumes the bank samples strobes on the rising edge of ref_clk.
`timescale 1ns/100ps
module mscr_host_model (
    input  wire logic       ref_clk,
    output logic [6:0]      regAddr,
    output logic            regWrEn,
    output logic [7:0]      regWrData,
    output logic            regRdEn,
    input  wire logic [7:0] regRdData
);
    initial begin
        regAddr   = 7'h00;
        regWrEn   = 1'b0;
        regWrData = 8'h00;
        regRdEn   = 1'b0;
    end

    // A FIFO size change is followed by a FIFO reset elsewhere; no reset port here.
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        regAddr   <= a;
        regWrData <= d;
        regWrEn   <= 1'b1;
        @(posedge ref_clk);
        regWrEn   <= 1'b0;
        regWrData <= ~d;
    endtask

    // Read data is taken one edge after the strobe edge and held until the next read
    task automatic rd(input logic [6:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        regAddr <= a;
        regRdEn <= 1'b1;
        @(posedge ref_clk);
        regRdEn <= 1'b0;
        @(posedge ref_clk);
        #1 d = regRdData;
    endtask
endmodule

// >>> mscr_pkg.sv
// Constants, field layouts and decoded-setting types for the motion sensor configuration bank.
// Assumes a 25 MHz ref_clk and the 7-bit register address / 8-bit data host port.
package mscr_pkg;

    localparam int            ADDR_W          = 7;
    localparam int            DATA_W          = 8;
    localparam logic [6:0]    GYRO_SETUP_ADDR = 7'h1B;
    localparam logic [6:0]    ACC_RANGE_ADDR  = 7'h1C;
    localparam logic [6:0]    ACC_FILTER_ADDR = 7'h1D;

    localparam logic [7:0]    REG_RESET_VAL      = 8'h00;
    localparam logic [7:0]    GYRO_WR_MASK       = 8'hFB;
    localparam logic [7:0]    ACC_RANGE_WR_MASK  = 8'hF8;
    localparam logic [7:0]    ACC_FILTER_WR_MASK = 8'hFF;
    localparam logic [7:0]    READ_ZERO          = 8'h00;

    localparam int            ST_MSB      = 7;
    localparam int            ST_LSB      = 5;
    localparam int            RANGE_MSB   = 4;
    localparam int            RANGE_LSB   = 3;
    localparam int            GYRO_FCHB_MSB = 1;
    localparam int            GYRO_FCHB_LSB = 0;
    localparam int            FIFO_MSB    = 7;
    localparam int            FIFO_LSB    = 6;
    localparam int            DEC2_MSB    = 5;
    localparam int            DEC2_LSB    = 4;
    localparam int            ACC_BYP_BIT = 3;
    localparam int            DLPF_MSB    = 2;
    localparam int            DLPF_LSB    = 0;

    localparam logic [1:0]    CODE0 = 2'h0;
    localparam logic [1:0]    CODE1 = 2'h1;
    localparam logic [1:0]    CODE2 = 2'h2;
    localparam logic [1:0]    CODE3 = 2'h3;
    localparam logic [2:0]    FILT_CODE7 = 3'h7;

    localparam logic [11:0]   GYRO_FS_250  = 12'h0FA;
    localparam logic [11:0]   GYRO_FS_500  = 12'h1F4;
    localparam logic [11:0]   GYRO_FS_1000 = 12'h3E8;
    localparam logic [11:0]   GYRO_FS_2000 = 12'h7D0;
    localparam logic [4:0]    ACC_FS_2G    = 5'h02;
    localparam logic [4:0]    ACC_FS_4G    = 5'h04;
    localparam logic [4:0]    ACC_FS_8G    = 5'h08;
    localparam logic [4:0]    ACC_FS_16G   = 5'h10;
    localparam logic [12:0]   FIFO_512B    = 13'h0200;
    localparam logic [12:0]   FIFO_1KB     = 13'h0400;
    localparam logic [12:0]   FIFO_2KB     = 13'h0800;
    localparam logic [12:0]   FIFO_4KB     = 13'h1000;
    localparam logic [5:0]    AVG_1        = 6'h01;
    localparam logic [5:0]    AVG_4        = 6'h04;
    localparam logic [5:0]    AVG_8        = 6'h08;
    localparam logic [5:0]    AVG_16       = 6'h10;
    localparam logic [5:0]    AVG_32       = 6'h20;

    localparam int            CLK_PERIOD_NS     = 40;
    localparam int            ON_TIME_BYPASS_NS = 1084000;
    localparam int            ON_TIME_AVG4_NS   = 1840000;
    localparam int            ON_TIME_AVG8_NS   = 2840000;
    localparam int            ON_TIME_AVG16_NS  = 4840000;
    localparam int            ON_TIME_AVG32_NS  = 8840000;
    // Rounds on-times up so a window is never shorter than asked
    localparam int            CEIL_ADJ           = CLK_PERIOD_NS - 1;
    localparam int            ON_TIME_BYPASS_CYC = (ON_TIME_BYPASS_NS + CEIL_ADJ) / CLK_PERIOD_NS;
    localparam int            ON_TIME_AVG4_CYC   = (ON_TIME_AVG4_NS + CEIL_ADJ) / CLK_PERIOD_NS;
    localparam int            ON_TIME_AVG8_CYC   = (ON_TIME_AVG8_NS + CEIL_ADJ) / CLK_PERIOD_NS;
    localparam int            ON_TIME_AVG16_CYC  = (ON_TIME_AVG16_NS + CEIL_ADJ) / CLK_PERIOD_NS;
    localparam int            ON_TIME_AVG32_CYC  = (ON_TIME_AVG32_NS + CEIL_ADJ) / CLK_PERIOD_NS;
    localparam int            ON_CNT_W           = 18;
    localparam logic [17:0]   ON_CNT_ZERO        = 18'h00000;
    localparam logic [17:0]   ON_CNT_ONE         = 18'h00001;
    localparam logic [7:0]    DIV_ZERO           = 8'h00;
    localparam logic [7:0]    DIV_ONE            = 8'h01;

    typedef enum logic [1:0] {
        GYRO_BW_8173,
        GYRO_BW_3281,
        GYRO_BW_BY_CODE
    } mscr_gyro_bw_e;

    typedef enum logic [2:0] {
        ACC_BW_1046,
        ACC_BW_218,
        ACC_BW_99,
        ACC_BW_45,
        ACC_BW_21,
        ACC_BW_10,
        ACC_BW_5,
        ACC_BW_420
    } mscr_acc_bw_e;

endpackage

// >>> tb.sv
// Self-checking bench for the configuration bank with shortened on-time counts.
// Assumes the host model above drives the register port.
`timescale 1ns/100ps
module tb;
    import mscr_pkg::*;
    logic ref_clk, rst_n, regWrEn, regRdEn, internalRate1k, internalSampleTick, accLowPowerMode;
    logic [6:0]  regAddr;
    logic [7:0]  regWrData, regRdData, outputRateDivider, d;
    logic [2:0]  gyroFilterCode, gyroSelfTestEn, accSelfTestEn, gyroFilterCodeUsed;
    logic [11:0] gyroFullScaleDps;
    logic [4:0]  accFullScaleG;
    logic [12:0] fifoSizeBytes;
    logic [5:0]  accAvgSamples;
    logic        outputSampleTick, accPowerOn;
    mscr_gyro_bw_e gyroBwSel;
    mscr_acc_bw_e  accBwSel;
    int errTotal = 0, compares = 0, outCnt = 0, powCnt = 0;

    mscr_host_model host (.ref_clk(ref_clk), .regAddr(regAddr), .regWrEn(regWrEn),
        .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData));
    mscr_config_regs #(.ON_BYPASS_CYC(3), .ON_AVG4_CYC(4), .ON_AVG8_CYC(5),
        .ON_AVG16_CYC(6), .ON_AVG32_CYC(7)) DUT (.ref_clk(ref_clk), .rst_n(rst_n),
        .regAddr(regAddr), .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn),
        .regRdData(regRdData), .outputRateDivider(outputRateDivider),
        .internalRate1k(internalRate1k), .internalSampleTick(internalSampleTick),
        .gyroFilterCode(gyroFilterCode), .accLowPowerMode(accLowPowerMode),
        .gyroSelfTestEn(gyroSelfTestEn), .accSelfTestEn(accSelfTestEn),
        .gyroFullScaleDps(gyroFullScaleDps), .accFullScaleG(accFullScaleG),
        .gyroBwSel(gyroBwSel), .gyroFilterCodeUsed(gyroFilterCodeUsed), .accBwSel(accBwSel),
        .fifoSizeBytes(fifoSizeBytes), .accAvgSamples(accAvgSamples),
        .outputSampleTick(outputSampleTick), .accPowerOn(accPowerOn));

    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk) begin
        if (outputSampleTick === 1'b1) outCnt = outCnt + 1;
        if (accPowerOn === 1'b1) powCnt = powCnt + 1;
    end

    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            errTotal++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // Ends on an edge: outputs are read before that edge's updates land
    task automatic settle();
        repeat (2) @(posedge ref_clk);
    endtask

    task automatic tick();
        @(posedge ref_clk);
        internalSampleTick <= 1'b1;
        @(posedge ref_clk);
        internalSampleTick <= 1'b0;
    endtask

    task automatic test_gyro();
        for (int c = 0; c < 4; c++) begin
            host.wr(GYRO_SETUP_ADDR, 8'hA4 | 8'(c << 3) | 8'(c));
            settle();
            chk("gyroFullScaleDps", 16'(250 << c), 16'(gyroFullScaleDps));
            chk("gyroBwSel", c[0] ? 16'h0 : (c ? 16'h1 : 16'h2), 16'(gyroBwSel));
            chk("gyroSelfTestEn", 16'h0005, 16'(gyroSelfTestEn));
            chk("gyroFilterCodeUsed", 16'h0003, 16'(gyroFilterCodeUsed));
            host.rd(GYRO_SETUP_ADDR, d);
            chk("gyro readback", 16'(8'hA0 | 8'(c << 3) | 8'(c)), 16'(d));
        end
        @(posedge ref_clk);
        gyroFilterCode <= 3'h7;
        host.wr(GYRO_SETUP_ADDR, 8'h00);
        settle();
        chk("gyroBwSel code7", 16'h0001, 16'(gyroBwSel));
        $display("test gyro done");
    endtask

    task automatic test_acc_range();
        for (int c = 0; c < 4; c++) begin
            host.wr(ACC_RANGE_ADDR, 8'h47 | 8'(c << 3));
            settle();
            chk("accFullScaleG", 16'(2 << c), 16'(accFullScaleG));
            chk("accSelfTestEn", 16'h0002, 16'(accSelfTestEn));
            host.rd(ACC_RANGE_ADDR, d);
            chk("acc range readback", 16'(8'h40 | 8'(c << 3)), 16'(d));
        end
        $display("test acc range done");
    endtask

    task automatic test_acc_filter();
        logic [7:0]  v;
        logic [15:0] e;
        for (int c = 0; c < 9; c++) begin
            v = {2'(c), 2'(c >> 1), (c == 8), 3'(c)};
            host.wr(ACC_FILTER_ADDR, v);
            settle();
            chk("fifoSizeBytes", 16'(512 << v[7:6]), 16'(fifoSizeBytes));
            chk("accAvgSamples", 16'(4 << v[5:4]), 16'(accAvgSamples));
            e = v[3] ? 16'h0 : (v[2:0] ? 16'(v[2:0]) : 16'h1);
            chk("accBwSel", e, 16'(accBwSel));
        end
        host.wr(7'h1E, 8'hFF);
        host.rd(7'h1E, d);
        chk("unmapped read", 16'h0000, 16'(d));
        host.rd(ACC_FILTER_ADDR, d);
        chk("acc filter readback", 16'(v), 16'(d));
        $display("test acc filter done");
    endtask

    task automatic test_divider();
        #1 outCnt = 0;
        for (int i = 0; i < 9; i++) tick();
        settle();
        chk("ticks div2", 16'h0003, 16'(outCnt));
        internalRate1k <= 1'b0;
        #1 outCnt = 0;
        for (int i = 0; i < 4; i++) tick();
        settle();
        chk("ticks no 1k", 16'h0004, 16'(outCnt));
        $display("test divider done");
    endtask

    task automatic test_duty();
        accLowPowerMode <= 1'b1;
        host.wr(ACC_FILTER_ADDR, 8'h08);
        settle();
        chk("avg bypass lp", 16'h0001, 16'(accAvgSamples));
        powCnt = 0;
        tick();
        repeat (15) @(posedge ref_clk);
        chk("on bypass", 16'h0003, 16'(powCnt));
        gyroFilterCode <= 3'h1;
        host.wr(ACC_FILTER_ADDR, 8'h30);
        settle();
        powCnt = 0;
        tick();
        tick();
        repeat (20) @(posedge ref_clk);
        chk("on avg32", 16'h0007, 16'(powCnt));
        $display("test duty done");
    endtask

    task automatic stop_test();
        $display("compares %0d mismatches %0d", compares, errTotal);
        if (errTotal == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial begin
        rst_n = 1'b0;
        internalRate1k = 1'b1;
        internalSampleTick = 1'b0;
        outputRateDivider = 8'h02;
        gyroFilterCode = 3'h3;
        accLowPowerMode = 1'b0;
        repeat (8) @(posedge ref_clk);
        rst_n <= 1'b1;
        settle();
        chk("reset fifo", 16'h0200, 16'(fifoSizeBytes));
        chk("reset accBwSel", 16'h0001, 16'(accBwSel));
        test_gyro();
        test_acc_range();
        test_acc_filter();
        test_divider();
        test_duty();
        stop_test();
    end

    initial begin
        repeat (5000) @(posedge ref_clk);
        errTotal++;
        stop_test();
    end
endmodule
